// file: pkg/state_word_pkg.sv
/*
 * constants for the processor state word block: field positions in the
 * 32-bit word, reset value, implemented-bit mask, interrupt class codes.
 * assumes the core pipeline drives one request per cycle on plain ports.
 */
`default_nettype none
package state_word_pkg;
	// ----------------------------------------------------------------
	// bit positions, lsb numbering (big-endian bit n is 31-n)
	// ----------------------------------------------------------------
	localparam int POS_USER_LOCK    = 26;
	localparam int POS_VECTOR_EXT   = 25;
	localparam int POS_WAIT_STATE   = 18;
	localparam int POS_CRIT_IRQ     = 17;
	localparam int POS_EXT_IRQ      = 15;
	localparam int POS_USER_STATE   = 14;
	localparam int POS_FLOAT_UNIT   = 13;
	localparam int POS_ASYNC_CHECK  = 12;
	localparam int POS_FLOAT_EXC0   = 11;
	localparam int POS_DBG_IRQ      = 9;
	localparam int POS_FLOAT_EXC1   = 8;
	localparam int POS_FETCH_SPACE  = 5;
	localparam int POS_DATA_SPACE   = 4;
	localparam int POS_PERF_MARK    = 2;
	localparam int POS_RECOVERABLE  = 1;
	// syndrome bits
	localparam int POS_SYN_DLOCK    = 21;
	localparam int POS_SYN_ILOCK    = 20;
	localparam int POS_SYN_VECTOR   = 7;
	localparam int POS_SYN_PRIV     = 26;
	localparam int POS_SYN_ILLEGAL  = 27;
	// ----------------------------------------------------------------
	// reset and masks
	// ----------------------------------------------------------------
	localparam logic [31:0] STATE_RESET  = 32'h0000_0000;
	localparam logic [31:0] STATE_MASK   = 32'h0606_fb36;
	// cleared on every interrupt entry except the enables kept per class
	localparam logic [31:0] KEEP_ON_IRQ  = 32'h0000_1200;
	localparam logic [31:0] KEEP_ON_CRIT = 32'h0000_1000;
	localparam logic [31:0] KEEP_ON_MCHK = 32'h0000_0000;
	localparam logic [31:0] KEEP_ON_DBG  = 32'h0000_1000;
	// ----------------------------------------------------------------
	// interrupt classes
	// ----------------------------------------------------------------
	localparam logic [1:0] CLASS_BASE = 2'h0;
	localparam logic [1:0] CLASS_CRIT = 2'h1;
	localparam logic [1:0] CLASS_DBG  = 2'h2;
	localparam logic [1:0] CLASS_MCHK = 2'h3;
endpackage
`default_nettype wire

// file: verilog/save_restore_pair.sv
/*
 * one save/restore register pair: return address and saved state.
 * assumes capture and software writes are never asked in the same cycle
 * by the pipeline; capture wins if they are.
 */
`default_nettype none
module save_restore_pair (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_sync_n,
	// capture on interrupt entry
	input  wire logic        capture,
	input  wire logic [31:0] cap_addr,
	input  wire logic [31:0] cap_state,
	// software writes
	input  wire logic        wr_addr,
	input  wire logic        wr_state,
	input  wire logic [31:0] wr_data,
	// contents
	output logic      [31:0] ret_addr,
	output logic      [31:0] saved_state
);
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] state;
	} pair_type;

	pair_type cur_ff;
	pair_type nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (capture) begin
			nxt_cur.addr  = cap_addr;
			nxt_cur.state = cap_state & state_word_pkg::STATE_MASK;
		end else begin
			if (wr_addr)
				nxt_cur.addr = wr_data;
			if (wr_state)
				nxt_cur.state = wr_data & state_word_pkg::STATE_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign ret_addr    = cur_ff.addr;
	assign saved_state = cur_ff.state;
endmodule
`default_nettype wire

// file: verilog/processor_state_control_reg.sv
/*
 * processor state word with its gating of interrupts and instruction
 * classes, plus save/restore pairs for all four interrupt classes.
 * assumes the pipeline offers at most one of: move-to, system call,
 * interrupt entry or return in a cycle; entry has priority if it does not.
 */
`default_nettype none
module processor_state_control_reg (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// software access to the state word
	input  wire logic        move_to_state,
	input  wire logic        system_call,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] processor_state_word,
	// save register writes by software, one bit per class
	input  wire logic [3:0]  wr_ret_addr,
	input  wire logic [3:0]  wr_saved_state,
	// interrupt entry and return
	input  wire logic        irq_take,
	input  wire logic [1:0]  irq_class,
	input  wire logic [31:0] resume_addr,
	input  wire logic        ret_take,
	input  wire logic [1:0]  ret_class,
	output logic      [31:0] resume_target,
	// interrupt requests
	input  wire logic        crit_input_req,
	input  wire logic        watchdog_req,
	input  wire logic        ext_input_req,
	input  wire logic        decrementer_req,
	input  wire logic        fixed_timer_req,
	input  wire logic        async_mchk_req,
	input  wire logic        dbg_req,
	output logic             crit_irq_pend,
	output logic             ext_irq_pend,
	output logic             mchk_irq_pend,
	output logic             dbg_irq_pend,
	// instruction screening
	input  wire logic        op_cache_lock_i,
	input  wire logic        op_cache_lock_d,
	input  wire logic        op_vector,
	input  wire logic        op_classic_float,
	input  wire logic        op_privileged,
	output logic             storage_fault_irq,
	output logic             unavailable_irq,
	output logic             program_irq,
	output logic      [31:0] exception_syndrome,
	// power management
	input  wire logic        pm_conditions_met,
	input  wire logic [2:0]  hw_config0_pm_sel,
	output logic      [2:0]  power_mode_req,
	// address space selection
	output logic             fetch_space_select,
	output logic             data_space_select,
	// save register contents
	output logic      [31:0] mchk_return_addr,
	output logic      [31:0] mchk_saved_state,
	output logic      [31:0] dbg_return_addr,
	output logic      [31:0] dbg_saved_state
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic       rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_sync_n = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// save/restore pairs, one per class
	// ----------------------------------------------------------------
	logic [31:0] pair_addr  [4];
	logic [31:0] pair_state [4];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pair
			save_restore_pair u_pair (
				.mclk        (mclk),
				.rst_sync_n  (rst_sync_n),
				.capture     (irq_take && irq_class == 2'(gi)),
				.cap_addr    (resume_addr),
				.cap_state   (processor_state_word),
				.wr_addr     (wr_ret_addr[gi]),
				.wr_state    (wr_saved_state[gi]),
				.wr_data     (wr_data),
				.ret_addr    (pair_addr[gi]),
				.saved_state (pair_state[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] word;
		logic [31:0] resume;
		logic [31:0] syndrome;
		logic        crit;
		logic        ext;
		logic        mchk;
		logic        dbg;
		logic        sfault;
		logic        unavail;
		logic        prog;
		logic [2:0]  pm;
		logic [31:0] mchk_addr;
		logic [31:0] mchk_state;
		logic [31:0] dbg_addr;
		logic [31:0] dbg_state;
	} ctl_type;

	ctl_type cur_ff;
	ctl_type nxt_cur;

	always_comb begin
		logic user;
		logic [31:0] keep;
		user = cur_ff.word[state_word_pkg::POS_USER_STATE];
		keep = state_word_pkg::KEEP_ON_IRQ;
		nxt_cur = cur_ff;
		// interrupt gating
		nxt_cur.crit = cur_ff.word[state_word_pkg::POS_CRIT_IRQ] &&
			(crit_input_req || watchdog_req);
		nxt_cur.ext = cur_ff.word[state_word_pkg::POS_EXT_IRQ] &&
			(ext_input_req || decrementer_req ||
			fixed_timer_req);
		nxt_cur.mchk = cur_ff.word[state_word_pkg::POS_ASYNC_CHECK] &&
			async_mchk_req;
		nxt_cur.dbg = cur_ff.word[state_word_pkg::POS_DBG_IRQ] &&
			dbg_req;
		// instruction screening; float enable and exc modes never consulted
		nxt_cur.sfault = user &&
			!cur_ff.word[state_word_pkg::POS_USER_LOCK] &&
			(op_cache_lock_i || op_cache_lock_d);
		nxt_cur.unavail = op_vector &&
			!cur_ff.word[state_word_pkg::POS_VECTOR_EXT];
		nxt_cur.prog = op_classic_float ||
			(user && op_privileged);
		if (nxt_cur.sfault) begin
			nxt_cur.syndrome = '0;
			nxt_cur.syndrome[state_word_pkg::POS_SYN_ILOCK] =
				op_cache_lock_i;
			nxt_cur.syndrome[state_word_pkg::POS_SYN_DLOCK] =
				op_cache_lock_d;
		end else if (nxt_cur.unavail) begin
			nxt_cur.syndrome = '0;
			nxt_cur.syndrome[state_word_pkg::POS_SYN_VECTOR] = 1'b1;
		end else if (nxt_cur.prog) begin
			nxt_cur.syndrome = '0;
			nxt_cur.syndrome[state_word_pkg::POS_SYN_ILLEGAL] =
				op_classic_float;
			nxt_cur.syndrome[state_word_pkg::POS_SYN_PRIV] =
				!op_classic_float;
		end
		// power saving only when allowed
		nxt_cur.pm = (cur_ff.word[state_word_pkg::POS_WAIT_STATE] &&
			pm_conditions_met) ? hw_config0_pm_sel : 3'h0;
		// state word updates, entry first
		if (irq_take) begin
			case (irq_class)
				state_word_pkg::CLASS_CRIT: keep = state_word_pkg::KEEP_ON_CRIT;
				state_word_pkg::CLASS_MCHK: keep = state_word_pkg::KEEP_ON_MCHK;
				state_word_pkg::CLASS_DBG:  keep = state_word_pkg::KEEP_ON_DBG;
				default:                    keep = state_word_pkg::KEEP_ON_IRQ;
			endcase
			// float enable is outside every keep mask so always drops
			nxt_cur.word = cur_ff.word & keep;
		end else if (ret_take) begin
			nxt_cur.word = pair_state[ret_class];
			nxt_cur.resume = pair_addr[ret_class];
		end else if (move_to_state || system_call) begin
			// system call keeps the pipeline's value form; same data path
			nxt_cur.word = wr_data & state_word_pkg::STATE_MASK;
		end
		// registered copies of the machine check and debug pairs for the ports
		nxt_cur.mchk_addr  = pair_addr[3];
		nxt_cur.mchk_state = pair_state[3];
		nxt_cur.dbg_addr   = pair_addr[2];
		nxt_cur.dbg_state  = pair_state[2];
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur_ff      <= '0;
			cur_ff.word <= state_word_pkg::STATE_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign processor_state_word = cur_ff.word;
	assign resume_target        = cur_ff.resume;
	assign exception_syndrome   = cur_ff.syndrome;
	assign crit_irq_pend        = cur_ff.crit;
	assign ext_irq_pend         = cur_ff.ext;
	assign mchk_irq_pend        = cur_ff.mchk;
	assign dbg_irq_pend         = cur_ff.dbg;
	assign storage_fault_irq    = cur_ff.sfault;
	assign unavailable_irq      = cur_ff.unavail;
	assign program_irq          = cur_ff.prog;
	assign power_mode_req       = cur_ff.pm;
	assign fetch_space_select   =
		cur_ff.word[state_word_pkg::POS_FETCH_SPACE];
	assign data_space_select    =
		cur_ff.word[state_word_pkg::POS_DATA_SPACE];
	assign mchk_return_addr     = cur_ff.mchk_addr;
	assign mchk_saved_state     = cur_ff.mchk_state;
	assign dbg_return_addr      = cur_ff.dbg_addr;
	assign dbg_saved_state      = cur_ff.dbg_state;
endmodule
`default_nettype wire

// file: bench/processor_state_control_reg_asserts.sv
/*
 * port checks on the processor state word block: gating, faults, power.
 * assumes one clock domain and the active-low reset at the top ports.
 */
`default_nettype none
module processor_state_control_reg_asserts (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// state and requests
	input wire logic [31:0] processor_state_word,
	input wire logic        crit_input_req,
	input wire logic        watchdog_req,
	input wire logic        ext_input_req,
	input wire logic        decrementer_req,
	input wire logic        fixed_timer_req,
	input wire logic        async_mchk_req,
	input wire logic        dbg_req,
	input wire logic        crit_irq_pend,
	input wire logic        ext_irq_pend,
	input wire logic        mchk_irq_pend,
	input wire logic        dbg_irq_pend,
	// screening and power
	input wire logic        op_cache_lock_i,
	input wire logic        op_cache_lock_d,
	input wire logic        op_vector,
	input wire logic        op_classic_float,
	input wire logic        storage_fault_irq,
	input wire logic        unavailable_irq,
	input wire logic        program_irq,
	input wire logic [31:0] exception_syndrome,
	input wire logic [2:0]  power_mode_req
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	localparam logic [31:0] IMPL = 32'h0606_fb36;
	logic [31:0] sw;
	logic [2:0]  live_ff;
	logic        live;
	assign sw = processor_state_word;
	// the design holds its own reset copy two edges longer than rst_n
	assign live = live_ff[2];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) live_ff <= 3'h0;
		else live_ff <= {live_ff[1:0], 1'b1};
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_crit_gate: assert property (live |=> crit_irq_pend == $past(
		(crit_input_req | watchdog_req) & sw[state_word_pkg::POS_CRIT_IRQ]))
		else $error("critical pending not gated by its enable");
	a_ext_gate: assert property (live |=> ext_irq_pend == $past(
		(ext_input_req | decrementer_req | fixed_timer_req)
		& sw[state_word_pkg::POS_EXT_IRQ]))
		else $error("external pending not gated by its enable");
	a_mchk_gate: assert property (live |=> mchk_irq_pend == $past(
		async_mchk_req & sw[state_word_pkg::POS_ASYNC_CHECK]))
		else $error("machine check pending not gated");
	a_dbg_gate: assert property (live |=> dbg_irq_pend == $past(
		dbg_req & sw[state_word_pkg::POS_DBG_IRQ]))
		else $error("debug pending not gated");
	a_lock_fault: assert property (live
		&& (op_cache_lock_i || op_cache_lock_d)
		&& sw[state_word_pkg::POS_USER_STATE]
		&& !sw[state_word_pkg::POS_USER_LOCK] |=> storage_fault_irq)
		else $error("user cache lock did not fault");
	a_vector_block: assert property (live && op_vector
		&& !op_cache_lock_i && !op_cache_lock_d
		&& !sw[state_word_pkg::POS_VECTOR_EXT] |=> unavailable_irq
		&& exception_syndrome[state_word_pkg::POS_SYN_VECTOR])
		else $error("vector op not blocked");
	a_float_illegal: assert property (live && op_classic_float
		|=> program_irq)
		else $error("classic float op not illegal");
	a_power_gate: assert property (live
		&& !sw[state_word_pkg::POS_WAIT_STATE] |=> power_mode_req == 3'h0)
		else $error("power saving without wait enable");
	a_reserved_zero: assert property ((sw & ~IMPL) == 32'h0)
		else $error("unimplemented state bit set");
endmodule
bind processor_state_control_reg processor_state_control_reg_asserts
	u_processor_state_control_reg_asserts (.mclk(mclk), .rst_n(rst_n),
	.processor_state_word(processor_state_word),
	.crit_input_req(crit_input_req), .watchdog_req(watchdog_req),
	.ext_input_req(ext_input_req), .decrementer_req(decrementer_req),
	.fixed_timer_req(fixed_timer_req), .async_mchk_req(async_mchk_req),
	.dbg_req(dbg_req), .crit_irq_pend(crit_irq_pend),
	.ext_irq_pend(ext_irq_pend), .mchk_irq_pend(mchk_irq_pend),
	.dbg_irq_pend(dbg_irq_pend), .op_cache_lock_i(op_cache_lock_i),
	.op_cache_lock_d(op_cache_lock_d), .op_vector(op_vector),
	.op_classic_float(op_classic_float),
	.storage_fault_irq(storage_fault_irq), .unavailable_irq(unavailable_irq),
	.program_irq(program_irq), .exception_syndrome(exception_syndrome),
	.power_mode_req(power_mode_req));
`default_nettype wire

// file: bench/test_processor_state_control_reg.sv
/*
 * bench for the processor state word block, driving every port itself.
 * assumes a 50 ns clock and registered results one edge after a strobe.
 */
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; \
	if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module test_processor_state_control_reg;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [31:0] IMPL = 32'h0606_fb36;
	logic        mclk = 1'b0, rst_n = 1'b0, move_to_state = 1'b0;
	logic        system_call = 1'b0, irq_take = 1'b0, ret_take = 1'b0;
	logic        pm_conditions_met = 1'b0;
	logic [31:0] wr_data = 32'h0, resume_addr = 32'h0, ra;
	logic [3:0]  wr_ret_addr = 4'h0, wr_saved_state = 4'h0, pend;
	logic [1:0]  irq_class = 2'h0, ret_class = 2'h0;
	logic [6:0]  req = 7'h0;
	logic [4:0]  ops = 5'h0;
	logic [2:0]  hw_config0_pm_sel = 3'h0, power_mode_req;
	logic [31:0] processor_state_word, resume_target, exception_syndrome;
	logic [31:0] mchk_return_addr, mchk_saved_state;
	logic [31:0] dbg_return_addr, dbg_saved_state;
	logic        storage_fault_irq, unavailable_irq, program_irq;
	logic        fetch_space_select, data_space_select;
	int          n_mismatch = 0, n_tests = 0;
	logic [33:0] ws;
	logic [63:0] mpair, dpair, rw;
	assign ws    = {processor_state_word, fetch_space_select,
		data_space_select};
	assign mpair = {mchk_return_addr, mchk_saved_state};
	assign dpair = {dbg_return_addr, dbg_saved_state};
	assign rw    = {resume_target, processor_state_word};
	logic [31:0] keep [4] = '{state_word_pkg::KEEP_ON_IRQ,
		state_word_pkg::KEEP_ON_CRIT, state_word_pkg::KEEP_ON_DBG,
		state_word_pkg::KEEP_ON_MCHK};
	processor_state_control_reg u_processor_state_control_reg (
		.mclk(mclk), .rst_n(rst_n), .move_to_state(move_to_state),
		.system_call(system_call), .wr_data(wr_data),
		.processor_state_word(processor_state_word),
		.wr_ret_addr(wr_ret_addr), .wr_saved_state(wr_saved_state),
		.irq_take(irq_take), .irq_class(irq_class), .resume_addr(resume_addr),
		.ret_take(ret_take), .ret_class(ret_class),
		.resume_target(resume_target), .crit_input_req(req[0]),
		.watchdog_req(req[1]), .ext_input_req(req[2]),
		.decrementer_req(req[3]), .fixed_timer_req(req[4]),
		.async_mchk_req(req[5]), .dbg_req(req[6]), .crit_irq_pend(pend[3]),
		.ext_irq_pend(pend[2]), .mchk_irq_pend(pend[1]),
		.dbg_irq_pend(pend[0]), .op_cache_lock_i(ops[4]),
		.op_cache_lock_d(ops[3]), .op_vector(ops[2]),
		.op_classic_float(ops[1]), .op_privileged(ops[0]),
		.storage_fault_irq(storage_fault_irq),
		.unavailable_irq(unavailable_irq), .program_irq(program_irq),
		.exception_syndrome(exception_syndrome),
		.pm_conditions_met(pm_conditions_met),
		.hw_config0_pm_sel(hw_config0_pm_sel), .power_mode_req(power_mode_req),
		.fetch_space_select(fetch_space_select),
		.data_space_select(data_space_select),
		.mchk_return_addr(mchk_return_addr),
		.mchk_saved_state(mchk_saved_state),
		.dbg_return_addr(dbg_return_addr), .dbg_saved_state(dbg_saved_state));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr_state(input logic [31:0] d, input logic sc);
		@(posedge mclk);
		move_to_state <= !sc;
		system_call <= sc;
		wr_data <= d;
		@(posedge mclk);
		move_to_state <= 1'b0;
		system_call <= 1'b0;
		#1;
	endtask
	// one decode strobe; faults stand for a single cycle, so look at once
	task automatic screen(input logic [31:0] s, input logic [4:0] o,
		input logic [2:0] f, input int b);
		wr_state(s, 1'b0);
		@(posedge mclk);
		ops <= o;
		@(posedge mclk);
		ops <= 5'h0;
		#1;
		`CHK("faults", f, {storage_fault_irq, unavailable_irq, program_irq})
		if (f !== 3'h0) `CHK("syndrome", 32'h1 << b, exception_syndrome)
	endtask
	task automatic ret(input logic [1:0] c);
		@(posedge mclk);
		ret_take <= 1'b1;
		ret_class <= c;
		@(posedge mclk);
		ret_take <= 1'b0;
		#1;
	endtask
	function automatic logic [3:0] grp(input int k);
		return k < 2 ? 4'h8 : k < 5 ? 4'h4 : k == 5 ? 4'h2 : 4'h1;
	endfunction
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial forever #25 mclk = ~mclk;
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		tick(3);
		`CHK("reset", 36'h0, {processor_state_word, pend})
		wr_state(32'hffff_ffff, 1'b0);
		`CHK("write", {IMPL, 2'h3}, ws)
		wr_state(32'h0000_0010, 1'b1);
		`CHK("syscall", {32'h10, 2'h1}, ws)
		for (int i = 0; i < 14; i++) begin
			wr_state(i < 7 ? 32'h0 : IMPL, 1'b0);
			@(posedge mclk);
			req <= 7'h1 << (i % 7);
			tick(2);
			`CHK("pending", i < 7 ? 4'h0 : grp(i % 7), pend)
			@(posedge mclk);
			req <= 7'h0;
		end
		screen(32'h0000_4000, 5'h10, 3'h4, 20);
		screen(32'h0000_4000, 5'h08, 3'h4, 21);
		screen(32'h0400_4000, 5'h18, 3'h0, 0);
		screen(32'h0000_0000, 5'h04, 3'h2, 7);
		screen(32'h0200_0000, 5'h04, 3'h0, 0);
		screen(32'h0200_2000, 5'h02, 3'h1, 27);
		screen(32'h0200_4000, 5'h01, 3'h1, 26);
		screen(32'h0200_0000, 5'h01, 3'h0, 0);
		pm_conditions_met <= 1'b1;
		hw_config0_pm_sel <= 3'h5;
		wr_state(32'h0, 1'b0);
		tick(2);
		`CHK("power off", 3'h0, power_mode_req)
		wr_state(32'h1 << state_word_pkg::POS_WAIT_STATE, 1'b0);
		tick(2);
		`CHK("power on", 3'h5, power_mode_req)
		for (int c = 0; c < 4; c++) begin
			ra = 32'h0000_4000 + 32'(c * 16);
			wr_state(IMPL, 1'b0);
			@(posedge mclk);
			irq_take <= 1'b1;
			irq_class <= 2'(c);
			resume_addr <= ra;
			@(posedge mclk);
			irq_take <= 1'b0;
			#1;
			`CHK("entry", IMPL & keep[c], processor_state_word)
			tick(2);
			if (c == 3) `CHK("mchk pair", {ra, IMPL}, mpair)
			if (c == 2) `CHK("dbg pair", {ra, IMPL}, dpair)
			ret(2'(c));
			`CHK("return", {ra, IMPL}, rw)
		end
		for (int c = 2; c < 4; c++) begin
			ra = 32'hffff_fff0 - 32'(c);
			@(posedge mclk);
			wr_ret_addr <= 4'h1 << c;
			wr_saved_state <= 4'h1 << c;
			wr_data <= ra;
			@(posedge mclk);
			wr_ret_addr <= 4'h0;
			wr_saved_state <= 4'h0;
			tick(2);
			if (c == 2) `CHK("pair write", ra, dbg_return_addr)
			else `CHK("pair write", ra, mchk_return_addr)
			ret(2'(c));
			`CHK("restore", {ra, ra & IMPL}, rw)
		end
		print_verdict();
	end
endmodule
`default_nettype wire
